// File: hdl/pmbus_ctl_pkg.sv
// Shared types of the power-bus command link.
// Needs nothing else.
package pmbus_ctl_pkg;
   typedef enum logic [1:0] {MARGIN_OFF, MARGIN_LO, MARGIN_HI} margin_t;
   typedef enum logic [1:0] {XFER_SEND, XFER_WRITE, XFER_READ} xfer_t;
   typedef enum logic [2:0] {D_IDLE, D_RX, D_ACK, D_TX, D_TXACK} dev_st_t;
   typedef enum logic [1:0] {H_IDLE, H_START, H_BIT, H_STOP} host_st_t;
endpackage

// File: hdl/pmbus_ctl_regs.svh
// Command codes, field positions, reset values and timing counts.
// Included by both link ends; holds definitions only.
`ifndef PMBUS_CTL_REGS_SVH
`define PMBUS_CTL_REGS_SVH
// Command codes
`define CMD_OUTPUT_CONTROL 8'h01
`define CMD_TURN_ON_CFG 8'h02
`define CMD_FAULT_CLEAR 8'h03
`define CMD_WRITE_LOCK 8'h10
`define CMD_STORE_ALL 8'h11
`define CMD_RESTORE_ALL 8'h12
// Output control fields
`define OC_RUN_BIT 7
`define OC_MARGIN_MSB 5
`define OC_MARGIN_LSB 2
`define OC_IMPL_MASK 8'hBC
`define OC_RESET 8'h00
`define MARGIN_LO_IGN 4'h5
`define MARGIN_LO_ACT 4'h6
`define MARGIN_HI_IGN 4'h9
`define MARGIN_HI_ACT 4'hA
// Turn-on source config: fixed ones, obey bits {cmd, pin}
`define CFG_FIXED_ONES 8'h13
`define CFG_OBEY_LSB 2
`define CFG_NVM_DEFAULT 2'h1
// Write lock levels
`define WL_ALL 8'h80
`define WL_OP 8'h40
`define WL_CFG 8'h20
`define WL_NONE 8'h00
`define WL_RESET 8'h00
// Slave address prefix
`define ADDR_PREFIX 3'h1
// Timing
`define MCLK_NS 100
`define NVM_COPY_NS 5000
`define NVM_COPY_CYC ((`NVM_COPY_NS + `MCLK_NS - 1) / `MCLK_NS)
`define SCL_NS 2500
`define SCL_QTR_CYC (`SCL_NS / (4 * `MCLK_NS))
// Host command port registers
`define HREG_TARGET 8'h00
`define HREG_CMD 8'h01
`define HREG_DATA 8'h02
`define HREG_GO 8'h03
`define HREG_STATUS 8'h04
`endif

// File: hdl/pmbus_dev_end.sv
// Device end: command decode, write lock, fault flags with alert,
// turn-on source logic and non-volatile copies of the obey bits.
// Assumes the link interface resolves the open-drain wires.
`timescale 1ns/1ns
`include "pmbus_ctl_regs.svh"

// Contract
// - Codes 01h, 02h, 10h are byte registers
// - Output control bit 7 runs converter
// - Bits 5:2 select margin high/low, fault action
// - Output control bits 6,1,0 ignored
// - Config bits 4,1,0 read as one
// - Config bit3 obeys command, bit2 obeys pin
// - Pin only: enable follows pin
// - Command only: enable follows run bit
// - Both: enable needs pin and run bit
// - Neither: enable after address detection
// - Write lock levels gate register writes
// - Fault clear 03h clears flags, releases alert
// - Persisting fault sets flag again at once
// - Fault clear never restarts latched converter
// - Restart needs source off then on
// - Host avoids fault clear without alert
// - Store-all 11h copies working to non-volatile
// - Restore-all 12h copies non-volatile to working
// - Copy allowed while running; bus may stall
// - Host limits store-all to 1000 cycles
// - Clear, store, restore are send-byte only
// - Unknown commands acked, ignored, flag comm fault
module pmbus_dev_end
   import pmbus_ctl_pkg::*;
#(
   parameter int NVM_COPY_CYC = `NVM_COPY_CYC
) (
   // Clock and resets
   input wire logic mclk,
   input wire logic nrst,
   input wire logic nvm_init_n,
   // Link
   pmbus_link_if.dev link,
   // Pins and analog side
   input wire logic [3:0] addr_sel,
   input wire logic addr_done,
   input wire logic en_pin,
   input wire logic [3:0] fault_raw,
   // Converter control
   output logic conv_run,
   output margin_t margin_sel,
   output logic margin_ignore_fault,
   output logic [4:0] status_flags
);
   logic [11:0] meta_q, sync_q;
   logic scl_p_q, sda_p_q;
   logic scl_s, sda_s, rise, fall, start, stop;
   logic [3:0] fault_s;
   dev_st_t st_q;
   logic [3:0] cnt_q;
   logic [7:0] sh_q, cmd_q, op_q, wl_q, rd_byte;
   logic [1:0] bidx_q, cfg_q, nvm_q;
   logic rw_q, oe_q, boot_q, latch_q, en_req, trip;
   logic byte_done, addr_hit, wr_stb, sb_stb, rd_stb, cml_set;
   logic clr_stb, store_stb, restore_stb, busy;
   logic [15:0] nvm_cnt_q;

   function automatic logic is_byte_reg(input logic [7:0] c);
      is_byte_reg = c == `CMD_OUTPUT_CONTROL || c == `CMD_TURN_ON_CFG || c == `CMD_WRITE_LOCK;
   endfunction

   function automatic logic wl_permits(input logic [7:0] wl, input logic [7:0] c);
      if (c == `CMD_WRITE_LOCK)
         wl_permits = 1'h1;
      else if (c == `CMD_OUTPUT_CONTROL)
         wl_permits = wl != `WL_ALL;
      else if (c == `CMD_TURN_ON_CFG)
         wl_permits = wl == `WL_NONE || wl == `WL_CFG;
      else
         wl_permits = wl == `WL_NONE;
   endfunction

   function automatic logic wl_valid(input logic [7:0] v);
      wl_valid = v == `WL_ALL || v == `WL_OP || v == `WL_CFG || v == `WL_NONE;
   endfunction

   // Synchronisers and edge history
   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         meta_q <= 12'h003;
         sync_q <= 12'h003;
         scl_p_q <= 1'h1;
         sda_p_q <= 1'h1;
      end else begin
         meta_q <= {addr_sel, addr_done, en_pin, fault_raw, link.scl, link.sda};
         sync_q <= meta_q;
         scl_p_q <= sync_q[1];
         sda_p_q <= sync_q[0];
      end
   end

   assign scl_s = sync_q[1];
   assign sda_s = sync_q[0];
   assign fault_s = sync_q[5:2];
   assign rise = scl_s && !scl_p_q;
   assign fall = !scl_s && scl_p_q;
   assign start = scl_s && scl_p_q && sda_p_q && !sda_s;
   assign stop = scl_s && scl_p_q && !sda_p_q && sda_s;

   // Transaction decode
   assign busy = nvm_cnt_q != 16'h0000;
   assign byte_done = fall && st_q == D_RX && cnt_q == 4'h8;
   assign addr_hit = sh_q[7:1] == {`ADDR_PREFIX, sync_q[11:8]};
   assign wr_stb = byte_done && bidx_q == 2'h2 && !rw_q;
   assign sb_stb = stop && st_q == D_RX && bidx_q == 2'h2 && cnt_q == 4'h1 && !rw_q;
   assign rd_stb = fall && st_q == D_ACK && bidx_q == 2'h0 && rw_q;
   assign clr_stb = sb_stb && cmd_q == `CMD_FAULT_CLEAR;
   assign store_stb = sb_stb && cmd_q == `CMD_STORE_ALL;
   assign restore_stb = sb_stb && cmd_q == `CMD_RESTORE_ALL;
   assign cml_set = ((wr_stb || rd_stb) && !is_byte_reg(cmd_q))
      || (wr_stb && cmd_q == `CMD_WRITE_LOCK && !wl_valid(sh_q))
      || (sb_stb && !clr_stb && !store_stb && !restore_stb);

   // Byte-level link engine
   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         st_q <= D_IDLE;
         cnt_q <= 4'h0;
         sh_q <= 8'h00;
         bidx_q <= 2'h0;
         rw_q <= 1'h0;
         oe_q <= 1'h0;
         cmd_q <= 8'h00;
      end else if (start && !busy) begin
         st_q <= D_RX;
         cnt_q <= 4'h0;
         bidx_q <= 2'h0;
         oe_q <= 1'h0;
      end else if (stop || busy) begin
         st_q <= D_IDLE;
         oe_q <= 1'h0;
      end else begin
         unique case (st_q)
            D_IDLE: begin
            end
            D_RX: begin
               if (rise) begin
                  sh_q <= {sh_q[6:0], sda_s};
                  cnt_q <= cnt_q + 4'h1;
               end else if (byte_done) begin
                  if (bidx_q == 2'h0 && !addr_hit) begin
                     st_q <= D_IDLE;
                  end else begin
                     st_q <= D_ACK;
                     oe_q <= 1'h1;
                     if (bidx_q == 2'h0)
                        rw_q <= sh_q[0];
                     if (bidx_q == 2'h1)
                        cmd_q <= sh_q;
                  end
               end
            end
            D_ACK: begin
               if (fall) begin
                  bidx_q <= bidx_q + {1'h0, bidx_q != 2'h3};
                  cnt_q <= 4'h0;
                  if (rd_stb) begin
                     st_q <= D_TX;
                     sh_q <= rd_byte;
                     oe_q <= !rd_byte[7];
                  end else begin
                     st_q <= D_RX;
                     oe_q <= 1'h0;
                  end
               end
            end
            D_TX: begin
               if (rise) begin
                  cnt_q <= cnt_q + 4'h1;
               end else if (fall) begin
                  if (cnt_q == 4'h8) begin
                     oe_q <= 1'h0;
                     st_q <= D_TXACK;
                  end else begin
                     oe_q <= !sh_q[6];
                     sh_q <= {sh_q[6:0], 1'h0};
                  end
               end
            end
            D_TXACK: begin
               if (rise) begin
                  if (!sda_s) begin
                     st_q <= D_ACK;
                     bidx_q <= 2'h0;
                  end else begin
                     st_q <= D_IDLE;
                  end
               end
            end
         endcase
      end
   end

   // Read-back of the byte registers
   always_comb begin
      case (cmd_q)
         `CMD_OUTPUT_CONTROL: rd_byte = op_q;
         `CMD_TURN_ON_CFG: rd_byte = `CFG_FIXED_ONES | {4'h0, cfg_q, 2'h0};
         `CMD_WRITE_LOCK: rd_byte = wl_q;
         default: rd_byte = 8'h00;
      endcase
   end

   // Output control and write lock registers
   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         op_q <= `OC_RESET;
         wl_q <= `WL_RESET;
      end else if (wr_stb && wl_permits(wl_q, cmd_q)) begin
         case (cmd_q)
            `CMD_OUTPUT_CONTROL: op_q <= sh_q & `OC_IMPL_MASK;
            `CMD_WRITE_LOCK: if (wl_valid(sh_q)) wl_q <= sh_q;
            default: begin
            end
         endcase
      end
   end

   // Obey bits, loaded from non-volatile copy at power-up
   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         cfg_q <= `CFG_NVM_DEFAULT;
         boot_q <= 1'h1;
      end else begin
         boot_q <= 1'h0;
         if (boot_q || restore_stb)
            cfg_q <= nvm_q;
         else if (wr_stb && cmd_q == `CMD_TURN_ON_CFG && wl_permits(wl_q, cmd_q))
            cfg_q <= sh_q[`CFG_OBEY_LSB+1:`CFG_OBEY_LSB];
      end
   end

   // Non-volatile cells and copy window
   always_ff @(posedge mclk or negedge nvm_init_n) begin
      if (!nvm_init_n)
         nvm_q <= `CFG_NVM_DEFAULT;
      else if (store_stb)
         nvm_q <= cfg_q;
   end

   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst)
         nvm_cnt_q <= 16'h0000;
      else if (store_stb || restore_stb)
         nvm_cnt_q <= 16'(NVM_COPY_CYC);
      else if (busy)
         nvm_cnt_q <= nvm_cnt_q - 16'h0001;
   end

   // Latched flags: set wins over clear
   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst)
         status_flags <= 5'h00;
      else
         status_flags <= (clr_stb ? 5'h00 : status_flags) | {cml_set, fault_s};
   end

   assign link.d_alert_o = 1'h0;
   assign link.d_alert_oe = |status_flags;
   assign link.d_sda_o = 1'h0;
   assign link.d_sda_oe = oe_q;

   // Enable source selection
   always_comb begin
      unique case (cfg_q)
         2'h0: en_req = sync_q[7];
         2'h1: en_req = sync_q[6];
         2'h2: en_req = op_q[`OC_RUN_BIT];
         2'h3: en_req = op_q[`OC_RUN_BIT] && sync_q[6];
      endcase
   end

   assign trip = |fault_s && !margin_ignore_fault;

   // Fault latch-off and run output
   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         latch_q <= 1'h0;
         conv_run <= 1'h0;
      end else begin
         latch_q <= trip || (latch_q && en_req);
         conv_run <= en_req && !latch_q && !trip;
      end
   end

   // Margin decode
   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         margin_sel <= MARGIN_OFF;
         margin_ignore_fault <= 1'h0;
      end else begin
         case (op_q[`OC_MARGIN_MSB:`OC_MARGIN_LSB])
            `MARGIN_LO_IGN, `MARGIN_LO_ACT: margin_sel <= MARGIN_LO;
            `MARGIN_HI_IGN, `MARGIN_HI_ACT: margin_sel <= MARGIN_HI;
            default: margin_sel <= MARGIN_OFF;
         endcase
         margin_ignore_fault <= op_q[`OC_MARGIN_MSB:`OC_MARGIN_LSB] == `MARGIN_LO_IGN
            || op_q[`OC_MARGIN_MSB:`OC_MARGIN_LSB] == `MARGIN_HI_IGN;
      end
   end
endmodule // pmbus_dev_end

// File: hdl/pmbus_host_end.sv
// Host end: runs send-byte, write-byte and read-byte transfers on the
// link, ordered through a small register port.
// Assumes the link interface resolves the open-drain wires.
`timescale 1ns/1ns
`include "pmbus_ctl_regs.svh"
module pmbus_host_end
   import pmbus_ctl_pkg::*;
#(
   parameter int QTR_CYC = `SCL_QTR_CYC
) (
   // Clock and reset
   input wire logic mclk,
   input wire logic nrst,
   // Link
   pmbus_link_if.host link,
   // Register port
   input wire logic [7:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [7:0] reg_rdata
);
   logic [1:0] meta_q, sync_q;
   logic [7:0] div_q, sh_q, cmd_q, wdata_q, rx_q;
   logic [6:0] tgt_q;
   xfer_t kind_q;
   host_st_t hst_q;
   logic [1:0] q_q;
   logic [2:0] k_q;
   logic [3:0] b_q;
   logic scl_q, sda_q, ackbad_q, nack_q, tick, go, sda_s;

   function automatic logic [7:0] tx_byte(input logic [2:0] k);
      case (k)
         3'h0: tx_byte = {tgt_q, 1'h0};
         3'h1: tx_byte = cmd_q;
         3'h2: tx_byte = wdata_q;
         default: tx_byte = {tgt_q, 1'h1};
      endcase
   endfunction

   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         meta_q <= 2'h3;
         sync_q <= 2'h3;
      end else begin
         meta_q <= {link.alert, link.sda};
         sync_q <= meta_q;
      end
   end

   assign sda_s = sync_q[0];
   assign go = reg_wr && reg_addr == `HREG_GO && hst_q == H_IDLE;
   assign tick = div_q == 8'(QTR_CYC - 1);

   // Quarter-bit divider
   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst)
         div_q <= 8'h00;
      else
         div_q <= (tick || hst_q == H_IDLE) ? 8'h00 : div_q + 8'h01;
   end

   // Bit sequencer
   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         hst_q <= H_IDLE;
         q_q <= 2'h0;
         k_q <= 3'h0;
         b_q <= 4'h0;
         sh_q <= 8'h00;
         scl_q <= 1'h1;
         sda_q <= 1'h1;
         ackbad_q <= 1'h0;
         nack_q <= 1'h0;
         rx_q <= 8'h00;
      end else if (go) begin
         hst_q <= H_START;
         q_q <= 2'h0;
         k_q <= 3'h0;
         nack_q <= 1'h0;
      end else if (tick) begin
         q_q <= q_q + 2'h1;
         unique case (hst_q)
            H_IDLE: begin
            end
            H_START: begin
               unique case (q_q)
                  2'h0: sda_q <= 1'h1;
                  2'h1: scl_q <= 1'h1;
                  2'h2: sda_q <= 1'h0;
                  2'h3: begin
                     scl_q <= 1'h0;
                     hst_q <= H_BIT;
                     b_q <= 4'h0;
                     sh_q <= tx_byte(k_q);
                  end
               endcase
            end
            H_BIT: begin
               unique case (q_q)
                  2'h0: sda_q <= (b_q != 4'h8 && k_q != 3'h4) ? sh_q[7] : 1'h1;
                  2'h1: scl_q <= 1'h1;
                  2'h2: begin
                     if (b_q != 4'h8)
                        sh_q <= {sh_q[6:0], sda_s};
                     ackbad_q <= sda_s;
                  end
                  2'h3: begin
                     scl_q <= 1'h0;
                     if (b_q != 4'h8) begin
                        b_q <= b_q + 4'h1;
                     end else if (k_q != 3'h4 && ackbad_q) begin
                        nack_q <= 1'h1;
                        hst_q <= H_STOP;
                     end else begin
                        b_q <= 4'h0;
                        case (k_q)
                           3'h0: begin
                              k_q <= 3'h1;
                              sh_q <= tx_byte(3'h1);
                           end
                           3'h1: begin
                              if (kind_q == XFER_SEND) begin
                                 hst_q <= H_STOP;
                              end else if (kind_q == XFER_WRITE) begin
                                 k_q <= 3'h2;
                                 sh_q <= tx_byte(3'h2);
                              end else begin
                                 k_q <= 3'h3;
                                 hst_q <= H_START;
                              end
                           end
                           3'h3: k_q <= 3'h4;
                           3'h4: begin
                              rx_q <= sh_q;
                              hst_q <= H_STOP;
                           end
                           default: hst_q <= H_STOP;
                        endcase
                     end
                  end
               endcase
            end
            H_STOP: begin
               unique case (q_q)
                  2'h0: sda_q <= 1'h0;
                  2'h1: scl_q <= 1'h1;
                  2'h2: sda_q <= 1'h1;
                  2'h3: hst_q <= H_IDLE;
               endcase
            end
         endcase
      end
   end

   assign link.h_scl_o = 1'h0;
   assign link.h_scl_oe = !scl_q;
   assign link.h_sda_o = 1'h0;
   assign link.h_sda_oe = !sda_q;

   // Command port registers
   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         tgt_q <= 7'h00;
         cmd_q <= 8'h00;
         wdata_q <= 8'h00;
         kind_q <= XFER_SEND;
      end else if (reg_wr) begin
         case (reg_addr)
            `HREG_TARGET: tgt_q <= reg_wdata[6:0];
            `HREG_CMD: cmd_q <= reg_wdata;
            `HREG_DATA: wdata_q <= reg_wdata;
            `HREG_GO: if (go) kind_q <= xfer_t'(reg_wdata[1:0]);
            default: begin
            end
         endcase
      end
   end

   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         reg_rdata <= 8'h00;
      end else if (reg_rd) begin
         case (reg_addr)
            `HREG_TARGET: reg_rdata <= {1'h0, tgt_q};
            `HREG_CMD: reg_rdata <= cmd_q;
            `HREG_DATA: reg_rdata <= rx_q;
            `HREG_STATUS: reg_rdata <= {5'h00, !sync_q[1], nack_q, hst_q != H_IDLE};
            default: reg_rdata <= 8'h00;
         endcase
      end
   end
endmodule // pmbus_host_end

// File: hdl/pmbus_link_if.sv
// Open-drain clock, data and alert wires between host and device.
// Each wire is high unless some end enables a low drive.
`timescale 1ns/1ns
interface pmbus_link_if;
   logic h_scl_o, h_scl_oe, h_sda_o, h_sda_oe;
   logic d_sda_o, d_sda_oe, d_alert_o, d_alert_oe;
   logic scl, sda, alert;
   assign scl = !(h_scl_oe && !h_scl_o);
   assign sda = !((h_sda_oe && !h_sda_o) || (d_sda_oe && !d_sda_o));
   assign alert = !(d_alert_oe && !d_alert_o);
   modport host(output h_scl_o, h_scl_oe, h_sda_o, h_sda_oe, input scl, sda, alert);
   modport dev(output d_sda_o, d_sda_oe, d_alert_o, d_alert_oe, input scl, sda);
endinterface

// File: tb/pmbus_link_props.sv
// Checker on the link wires and the device outputs.
// Instantiated by the bench beside the link interface.
`timescale 1ns/1ns
module pmbus_link_props (
   // Clock and reset
   input wire logic mclk,
   input wire logic nrst,
   // Link wires and device drives
   input wire logic scl,
   input wire logic sda,
   input wire logic d_sda_o,
   input wire logic d_sda_oe,
   input wire logic d_alert_o,
   input wire logic d_alert_oe,
   // Device outputs
   input wire logic conv_run,
   input wire logic margin_ignore_fault,
   input wire logic [1:0] margin_sel,
   input wire logic [4:0] status_flags,
   // Raw fault inputs of the device
   input wire logic [3:0] fault_raw
);
   default clocking cb
      @(posedge mclk);
   endclocking
   default disable iff (!nrst);
   property p_alert_on;
      (|status_flags) |-> ##[0:2] (d_alert_oe && !d_alert_o);
   endproperty
   a_alert_on: assert property (p_alert_on) else $error("alert idle with flags set");
   property p_ign_margin;
      margin_ignore_fault |-> margin_sel != 2'h0;
   endproperty
   a_ign_margin: assert property (p_ign_margin) else $error("ignore without margin");
   property p_relatch;
      (fault_raw != 4'h0 && $stable(fault_raw))[*4]
         |-> (status_flags[3:0] & fault_raw) == fault_raw;
   endproperty
   a_relatch: assert property (p_relatch) else $error("live fault not flagged");
   property p_trip_stops;
      ($rose(|status_flags[3:0]) && !margin_ignore_fault) |-> ##[0:4] !conv_run;
   endproperty
   a_trip_stops: assert property (p_trip_stops) else $error("converter kept running");
   property p_clear_at_stop;
      $fell(status_flags[4]) |-> scl && sda;
   endproperty
   a_clear_at_stop: assert property (p_clear_at_stop) else $error("flag dropped mid frame");
   property p_sda_turn;
      $changed(d_sda_oe) |-> !scl && !d_sda_o;
   endproperty
   a_sda_turn: assert property (p_sda_turn) else $error("device data moved, clock high");
   property p_scl_low_min;
      $fell(scl) |=> (!scl)[*3];
   endproperty
   a_scl_low_min: assert property (p_scl_low_min) else $error("clock low too short");
   property p_scl_high_min;
      $rose(scl) |=> scl[*3];
   endproperty
   a_scl_high_min: assert property (p_scl_high_min) else $error("clock high too short");
endmodule // pmbus_link_props

// File: tb/test_pmbus_output_control_cmds.sv
// Bench: host end and device end joined by the link interface.
// Drives the host register port and the device pins; needs hdl/.
`timescale 1ns/1ns
`include "pmbus_ctl_regs.svh"
module test_pmbus_output_control_cmds
   import pmbus_ctl_pkg::*;
;
   logic mclk, nrst = 1'b0, nvm_init_n = 1'b0, addr_done = 1'b0, en_pin = 1'b0;
   logic [3:0] addr_sel = 4'h0, fault_raw = 4'h0;
   logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata, d;
   logic reg_wr = 1'b0, reg_rd = 1'b0, rd_note = 1'b0, rd_seen = 1'b0;
   logic conv_run, margin_ignore_fault;
   logic [4:0] status_flags;
   margin_t margin_sel;
   logic [7:0] notes[$];
   logic [3:0] codes[6] = '{4'h0, 4'h3, 4'h5, 4'h6, 4'h9, 4'hA};
   margin_t mexp[6] = '{MARGIN_OFF, MARGIN_OFF, MARGIN_LO, MARGIN_LO, MARGIN_HI, MARGIN_HI};
   int err_count = 0, check_count = 0;
   pmbus_link_if link();
   pmbus_host_end i_pmbus_host_end (.mclk(mclk), .nrst(nrst), .link(link.host),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_rdata(reg_rdata));
   pmbus_dev_end #(.NVM_COPY_CYC(4)) i_pmbus_dev_end (.mclk(mclk), .nrst(nrst),
      .nvm_init_n(nvm_init_n), .link(link.dev), .addr_sel(addr_sel), .addr_done(addr_done),
      .en_pin(en_pin), .fault_raw(fault_raw), .conv_run(conv_run), .margin_sel(margin_sel),
      .margin_ignore_fault(margin_ignore_fault), .status_flags(status_flags));
   pmbus_link_props i_pmbus_link_props (.mclk(mclk), .nrst(nrst), .scl(link.scl),
      .sda(link.sda), .d_sda_o(link.d_sda_o), .d_sda_oe(link.d_sda_oe),
      .d_alert_o(link.d_alert_o), .d_alert_oe(link.d_alert_oe), .conv_run(conv_run),
      .margin_ignore_fault(margin_ignore_fault), .margin_sel(margin_sel),
      .status_flags(status_flags), .fault_raw(fault_raw));
   task automatic cmp(string what, logic [7:0] e, logic [7:0] s);
      check_count++;
      if (s !== e) begin
         err_count++;
         $display("FAIL %s expected %h seen %h", what, e, s);
      end
   endtask
   task automatic wr(logic [7:0] a, logic [7:0] v);
      reg_addr <= a;
      reg_wdata <= v;
      reg_wr <= 1'b1;
      @(posedge mclk);
      reg_wr <= 1'b0;
      @(posedge mclk);
   endtask
   task automatic rd(logic [7:0] a, logic [7:0] e, logic note);
      reg_addr <= a;
      reg_rd <= 1'b1;
      rd_note <= note;
      if (note) notes.push_back(e);
      @(posedge mclk);
      reg_rd <= 1'b0;
      rd_note <= 1'b0;
      @(posedge mclk);
   endtask
   // Read results checked one cycle after the strobe
   always @(posedge mclk) begin
      rd_seen <= rd_note;
      if (rd_seen) cmp("rdata", notes.pop_front(), reg_rdata);
   end
   task automatic xfer(logic [7:0] c, logic [7:0] v, logic [1:0] k);
      int n = 0;
      wr(`HREG_CMD, c);
      wr(`HREG_DATA, v);
      wr(`HREG_GO, {6'h00, k});
      do begin
         rd(`HREG_STATUS, 8'h00, 1'b0);
         n++;
      end while (reg_rdata[0] !== 1'b0 && n < 3000);
      cmp("status", 8'h00, reg_rdata & 8'h03);
      repeat (8) @(posedge mclk);
   endtask
   task automatic rdreg(logic [7:0] c, logic [7:0] e);
      xfer(c, 8'h00, 2'h2);
      rd(`HREG_DATA, e, 1'b1);
   endtask
   task automatic boot();
      nrst <= 1'b0;
      repeat (12) @(posedge mclk);
      nrst <= 1'b1;
      repeat (3) @(posedge mclk);
      wr(`HREG_TARGET, {1'b0, `ADDR_PREFIX, addr_sel});
   endtask
   task automatic print_verdict();
      if (err_count == 0 && check_count > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask
   initial begin
      mclk = 1'b0;
      forever #50 mclk = ~mclk;
   end
   initial begin
      repeat (95000) @(posedge mclk);
      err_count++;
      $display("FAIL watchdog expected finish seen timeout");
      print_verdict();
   end
   initial begin
      void'($urandom(32'h3282_e57e));
      addr_sel <= 4'($urandom);
      @(posedge mclk);
      nvm_init_n <= 1'b1;
      boot();
      addr_done <= 1'b1;
      rdreg(`CMD_OUTPUT_CONTROL, `OC_RESET);
      rdreg(`CMD_TURN_ON_CFG, 8'h17);
      rdreg(`CMD_WRITE_LOCK, `WL_RESET);
      rd(8'h3C, 8'h00, 1'b1);
      for (int m = 0; m < 4; m++) begin
         xfer(`CMD_TURN_ON_CFG, {4'h0, 2'(m), 2'h0}, 2'h1);
         rdreg(`CMD_TURN_ON_CFG, {4'h1, 2'(m), 2'h3});
         for (int v = 0; v < 4; v++) begin
            en_pin <= v[0];
            xfer(`CMD_OUTPUT_CONTROL, {v[1], 7'h00} | (8'($urandom) & 8'h43), 2'h1);
            d = 8'(m == 0 ? 1 : m == 1 ? v[0] : m == 2 ? v[1] : v[0] & v[1]);
            cmp("run", d, conv_run);
         end
      end
      foreach (codes[i]) begin
         d = {1'b1, 1'($urandom), codes[i], 2'($urandom)};
         xfer(`CMD_OUTPUT_CONTROL, d, 2'h1);
         rdreg(`CMD_OUTPUT_CONTROL, d & `OC_IMPL_MASK);
         cmp("margin", 8'(mexp[i]), 8'(margin_sel));
         cmp("ignore", 8'(i == 2 || i == 4), margin_ignore_fault);
      end
      xfer(`CMD_OUTPUT_CONTROL, 8'h80, 2'h1);
      xfer(`CMD_WRITE_LOCK, `WL_ALL, 2'h1);
      xfer(`CMD_OUTPUT_CONTROL, 8'h00, 2'h1);
      rdreg(`CMD_OUTPUT_CONTROL, 8'h80);
      xfer(`CMD_WRITE_LOCK, `WL_OP, 2'h1);
      xfer(`CMD_OUTPUT_CONTROL, 8'h98, 2'h1);
      xfer(`CMD_TURN_ON_CFG, 8'h00, 2'h1);
      rdreg(`CMD_OUTPUT_CONTROL, 8'h98);
      rdreg(`CMD_TURN_ON_CFG, 8'h1F);
      xfer(`CMD_WRITE_LOCK, `WL_CFG, 2'h1);
      xfer(`CMD_TURN_ON_CFG, 8'h08, 2'h1);
      xfer(`CMD_WRITE_LOCK, 8'h55, 2'h1);
      rdreg(`CMD_TURN_ON_CFG, 8'h1B);
      rdreg(`CMD_WRITE_LOCK, `WL_CFG);
      cmp("comm", 8'h10, status_flags);
      xfer(`CMD_WRITE_LOCK, `WL_NONE, 2'h1);
      xfer(`CMD_FAULT_CLEAR, 8'h00, 2'h0);
      cmp("flags", 8'h00, status_flags);
      xfer(8'h7E, 8'h00, 2'h1);
      cmp("comm", 8'h10, status_flags);
      xfer(`CMD_FAULT_CLEAR, 8'h00, 2'h0);
      rdreg(8'h7C, 8'h00);
      cmp("comm", 8'h10, status_flags);
      xfer(`CMD_FAULT_CLEAR, 8'h00, 2'h0);
      xfer(8'h7D, 8'h00, 2'h0);
      cmp("comm", 8'h10, status_flags);
      xfer(`CMD_FAULT_CLEAR, 8'h00, 2'h0);
      cmp("run", 8'h01, conv_run);
      fault_raw <= 4'h2;
      repeat (10) @(posedge mclk);
      cmp("run", 8'h00, conv_run);
      xfer(`CMD_FAULT_CLEAR, 8'h00, 2'h0);
      cmp("flags", 8'h02, status_flags);
      rd(`HREG_STATUS, 8'h04, 1'b1);
      fault_raw <= 4'h0;
      xfer(`CMD_FAULT_CLEAR, 8'h00, 2'h0);
      cmp("flags", 8'h00, status_flags);
      cmp("alert", 8'h01, link.alert);
      cmp("run", 8'h00, conv_run);
      xfer(`CMD_OUTPUT_CONTROL, 8'h18, 2'h1);
      xfer(`CMD_OUTPUT_CONTROL, 8'h98, 2'h1);
      cmp("run", 8'h01, conv_run);
      xfer(`CMD_STORE_ALL, 8'h00, 2'h0);
      cmp("run", 8'h01, conv_run);
      xfer(`CMD_TURN_ON_CFG, 8'h04, 2'h1);
      rdreg(`CMD_TURN_ON_CFG, 8'h17);
      xfer(`CMD_RESTORE_ALL, 8'h00, 2'h0);
      rdreg(`CMD_TURN_ON_CFG, 8'h1B);
      xfer(`CMD_TURN_ON_CFG, 8'h04, 2'h1);
      boot();
      rdreg(`CMD_TURN_ON_CFG, 8'h1B);
      repeat (4) @(posedge mclk);
      print_verdict();
   end
endmodule // test_pmbus_output_control_cmds
